/* File: rtl/alu_unit.sv */
// Result and carry of one executed instruction
`timescale 1ns/10ps
`default_nettype none
`include "exec_regs.svh"

module alu_unit import exec_pkg::*; (
	// Operation and operands
	input wire op_t op,
	input wire logic [7:0] acc,
	input wire logic [7:0] operand,
	input wire logic [7:0] imm,
	input wire logic [2:0] bit_idx,
	input wire logic carry_in,
	input wire logic aux_in,
	// Results
	output logic [7:0] result,
	output logic carry_out
);

	logic [7:0] adjust;
	logic [8:0] adj_sum;

	always_comb begin
		adjust = 8'h00;
		if ((acc[3:0] > `NIBBLE_LIMIT) || aux_in) begin
			adjust = adjust | `ADJ_LOW;
		end
		if ((acc[7:4] > `NIBBLE_LIMIT) || carry_in) begin
			adjust = adjust | `ADJ_HIGH;
		end
		adj_sum = {1'b0, acc} + {1'b0, adjust};
		result = operand;
		carry_out = carry_in;
		case (op)
			op_and_acc_mem, op_and_to_memory: result = acc & operand;
			op_and_acc_imm: result = acc & imm;
			op_or_acc_mem, op_or_to_memory: result = acc | operand;
			op_or_acc_imm: result = acc | imm;
			op_clear_mem: result = 8'h00;
			op_clear_bit: begin
				result = operand & ~(8'h01 << bit_idx);
			end
			op_invert_memory, op_invert_to_acc: result = ~operand;
			op_decimal_adjust: begin
				result = adj_sum[7:0];
				// High correction alone means the decimal sum passed 100
				carry_out = adj_sum[8] | adjust[5];
			end
			op_decrement_memory, op_decrement_to_acc: begin
				result = operand - 8'h01;
			end
			op_increment_memory, op_increment_to_acc: begin
				result = operand + 8'h01;
			end
			op_move_imm_to_acc, op_return_imm: result = imm;
			op_move_acc_to_mem: result = acc;
			op_rotate_left, op_rotate_left_to_acc: begin
				result = {operand[6:0], operand[7]};
			end
			op_rotate_left_carry: begin
				result = {operand[6:0], carry_in};
				carry_out = operand[7];
			end
			default: result = operand;
		endcase
	end

endmodule // alu_unit

`default_nettype wire

/* File: rtl/mcu_instruction_execute.sv */
// Instruction execute core with data memory, stack and watchdog
`timescale 1ns/10ps
`default_nettype none
`include "exec_regs.svh"

module mcu_instruction_execute import exec_pkg::*; (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Instruction from the sequencer
	input wire logic instr_valid,
	input wire instr_t instr,
	output logic instr_ready,
	// Interrupt and wake
	input wire logic irq_pending,
	input wire logic wake,
	// Register port
	input wire bus_req_t bus,
	output logic [7:0] bus_rdata,
	// Core state
	output logic [`PC_W-1:0] pc,
	output logic [7:0] acc,
	output flags_t flags,
	output logic master_irq_enable,
	output logic clock_stop,
	output logic [7:0] watchdog_counter
);

	exec_state_t s_q;
	exec_state_t s_d;

	logic [7:0] operand;
	logic [7:0] alu_result;
	logic alu_carry;
	logic fire;
	logic wd_overflow;
	logic [`PC_W-1:0] pc_next;
	logic [`SP_W-1:0] sp_pop;
	logic result_zero;

	assign operand = s_q.mem[instr.mem_addr];
	assign fire = instr_valid & s_q.ready;
	assign pc_next = s_q.pc + `PC_W'(1);
	assign sp_pop = s_q.sp - `SP_W'(1);
	assign result_zero = (alu_result == 8'h00);
	assign wd_overflow = (s_q.prescale == `PRESCALE_MAX) &&
		(s_q.watchdog_counter == `WATCHDOG_MAX);

	alu_unit alu (
		.op(instr.op),
		.acc(s_q.acc),
		.operand(operand),
		.imm(instr.imm),
		.bit_idx(instr.bit_idx),
		.carry_in(s_q.flags.carry),
		.aux_in(s_q.flags.aux_carry_flag),
		.result(alu_result),
		.carry_out(alu_carry)
	);

	always_comb begin
		s_d = s_q;
		s_d.rdata = 8'h00;

		// Register reads answer in the next cycle only
		if (bus.rd) begin
			if (bus.addr[7:5] == `REG_MEM_SEL) begin
				s_d.rdata = s_q.mem[bus.addr[`MEM_AW-1:0]];
			end else begin
				case (bus.addr)
					`REG_ACC: s_d.rdata = s_q.acc;
					`REG_STATUS: s_d.rdata = {3'h0, s_q.flags};
					`REG_CTRL: begin
						s_d.rdata = {6'h00, s_q.fsm[3],
							s_q.master_irq_enable};
					end
					`REG_PC_LO: s_d.rdata = s_q.pc[7:0];
					`REG_PC_HI: s_d.rdata = {5'h00, s_q.pc[`PC_W-1:8]};
					`REG_WATCHDOG: s_d.rdata = s_q.watchdog_counter;
					`REG_SP: s_d.rdata = {5'h00, s_q.sp};
					default: s_d.rdata = 8'h00;
				endcase
			end
		end

		// Register writes land first so an executing instruction wins
		if (bus.wr) begin
			if (bus.addr[7:5] == `REG_MEM_SEL) begin
				s_d.mem[bus.addr[`MEM_AW-1:0]] = bus.wdata;
			end else begin
				case (bus.addr)
					`REG_ACC: s_d.acc = bus.wdata;
					`REG_STATUS: s_d.flags = bus.wdata[4:0];
					`REG_CTRL: begin
						s_d.master_irq_enable = bus.wdata[`CTRL_IRQ_EN];
						if (bus.wdata[`CTRL_WAKE] && (s_q.fsm == st_halt)) begin
							s_d.fsm = st_run;
						end
					end
					default: s_d.acc = s_d.acc;
				endcase
			end
		end

		// Watchdog keeps counting through halt, as it can wake the core
		s_d.prescale = s_q.prescale + 8'h01;
		if (s_q.prescale == `PRESCALE_MAX) begin
			s_d.watchdog_counter = s_q.watchdog_counter + 8'h01;
		end

		case (s_q.fsm)
			st_run: begin
				if (fire) begin
					s_d.pc = pc_next;
					// Any other instruction breaks a pre-clear pair
					s_d.last_pre_a = 1'b0;
					s_d.last_pre_b = 1'b0;
					case (instr.op)
						op_and_acc_mem, op_and_acc_imm,
						op_or_acc_mem, op_or_acc_imm,
						op_invert_to_acc, op_decrement_to_acc,
						op_increment_to_acc: begin
							s_d.acc = alu_result;
							s_d.flags.zero = result_zero;
						end
						op_and_to_memory, op_or_to_memory,
						op_invert_memory, op_decrement_memory,
						op_increment_memory: begin
							s_d.mem[instr.mem_addr] = alu_result;
							s_d.flags.zero = result_zero;
						end
						op_clear_mem, op_clear_bit, op_move_acc_to_mem,
						op_rotate_left: begin
							s_d.mem[instr.mem_addr] = alu_result;
						end
						op_rotate_left_to_acc: begin
							s_d.acc = alu_result;
						end
						op_rotate_left_carry: begin
							s_d.mem[instr.mem_addr] = alu_result;
							s_d.flags.carry = alu_carry;
						end
						op_decimal_adjust: begin
							s_d.mem[instr.mem_addr] = alu_result;
							s_d.flags.carry = alu_carry;
						end
						op_move_mem_to_acc: begin
							s_d.acc = operand;
						end
						op_move_imm_to_acc: begin
							s_d.acc = alu_result;
						end
						op_call: begin
							s_d.stack[s_q.sp] = pc_next;
							s_d.sp = s_q.sp + `SP_W'(1);
							s_d.pc = instr.target;
							s_d.fsm = st_dummy;
						end
						op_jump: begin
							s_d.pc = instr.target;
							s_d.fsm = st_dummy;
						end
						op_return: begin
							s_d.sp = sp_pop;
							s_d.pc = s_q.stack[sp_pop];
							s_d.fsm = st_dummy;
						end
						op_return_imm: begin
							s_d.sp = sp_pop;
							s_d.pc = s_q.stack[sp_pop];
							s_d.acc = alu_result;
							s_d.fsm = st_dummy;
						end
						op_interrupt_return: begin
							s_d.sp = sp_pop;
							s_d.pc = s_q.stack[sp_pop];
							s_d.master_irq_enable = 1'b1;
							s_d.fsm = st_dummy;
						end
						op_watchdog_clear: begin
							s_d.prescale = 8'h00;
							s_d.watchdog_counter = 8'h00;
							s_d.flags.timeout_flag = 1'b0;
							s_d.flags.powerdown_flag = 1'b0;
						end
						op_watchdog_preclear_a, op_watchdog_preclear_b: begin
							// A repeat of the same half only re-arms itself
							if ((instr.op == op_watchdog_preclear_a &&
								s_q.last_pre_b) ||
								(instr.op == op_watchdog_preclear_b &&
								s_q.last_pre_a)) begin
								s_d.prescale = 8'h00;
								s_d.watchdog_counter = 8'h00;
								s_d.flags.timeout_flag = 1'b0;
								s_d.flags.powerdown_flag = 1'b0;
							end else begin
								s_d.last_pre_a =
									(instr.op == op_watchdog_preclear_a);
								s_d.last_pre_b =
									(instr.op == op_watchdog_preclear_b);
							end
						end
						op_halt: begin
							s_d.prescale = 8'h00;
							s_d.watchdog_counter = 8'h00;
							s_d.flags.timeout_flag = 1'b0;
							s_d.flags.powerdown_flag = 1'b1;
							s_d.fsm = st_halt;
						end
						default: s_d.pc = pc_next;
					endcase
				end else if (s_q.master_irq_enable && irq_pending) begin
					s_d.stack[s_q.sp] = s_q.pc;
					s_d.sp = s_q.sp + `SP_W'(1);
					s_d.pc = `IRQ_VECTOR;
					s_d.master_irq_enable = 1'b0;
					s_d.fsm = st_vector;
				end
			end
			st_dummy: begin
				// A request waiting at interrupt return goes before the
				// main program resumes
				if (s_q.master_irq_enable && irq_pending) begin
					s_d.stack[s_q.sp] = s_q.pc;
					s_d.sp = s_q.sp + `SP_W'(1);
					s_d.pc = `IRQ_VECTOR;
					s_d.master_irq_enable = 1'b0;
					s_d.fsm = st_vector;
				end else begin
					s_d.fsm = st_run;
				end
			end
			st_vector: begin
				s_d.fsm = st_run;
			end
			st_halt: begin
				// Only the wake input, the watchdog and register port writes change state while the clock is off
				if (wake || wd_overflow) begin
					s_d.fsm = st_run;
				end
			end
			default: s_d.fsm = st_run;
		endcase

		// Hardware set wins over any clear in the same cycle
		if (wd_overflow) begin
			s_d.flags.timeout_flag = 1'b1;
		end

		s_d.ready = (s_d.fsm == st_run);
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
			s_q.fsm <= st_run;
			s_q.ready <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign instr_ready = s_q.ready;
	assign bus_rdata = s_q.rdata;
	assign pc = s_q.pc;
	assign acc = s_q.acc;
	assign flags = s_q.flags;
	assign master_irq_enable = s_q.master_irq_enable;
	assign clock_stop = s_q.fsm[3];
	assign watchdog_counter = s_q.watchdog_counter;

endmodule // mcu_instruction_execute

`default_nettype wire

/* File: shared/exec_pkg.sv */
// Types for the instruction execute block
`include "exec_regs.svh"

package exec_pkg;

	typedef enum logic [4:0] {
		op_nop = 5'h00,
		op_and_acc_mem = 5'h01,
		op_and_acc_imm = 5'h02,
		op_and_to_memory = 5'h03,
		op_or_acc_mem = 5'h04,
		op_or_acc_imm = 5'h05,
		op_or_to_memory = 5'h06,
		op_call = 5'h07,
		op_jump = 5'h08,
		op_return = 5'h09,
		op_return_imm = 5'h0a,
		op_interrupt_return = 5'h0b,
		op_clear_mem = 5'h0c,
		op_clear_bit = 5'h0d,
		op_watchdog_clear = 5'h0e,
		op_watchdog_preclear_a = 5'h0f,
		op_watchdog_preclear_b = 5'h10,
		op_invert_memory = 5'h11,
		op_invert_to_acc = 5'h12,
		op_decimal_adjust = 5'h13,
		op_decrement_memory = 5'h14,
		op_decrement_to_acc = 5'h15,
		op_increment_memory = 5'h16,
		op_increment_to_acc = 5'h17,
		op_move_mem_to_acc = 5'h18,
		op_move_imm_to_acc = 5'h19,
		op_move_acc_to_mem = 5'h1a,
		op_halt = 5'h1b,
		op_rotate_left = 5'h1c,
		op_rotate_left_to_acc = 5'h1d,
		op_rotate_left_carry = 5'h1e
	} op_t;

	typedef enum logic [3:0] {
		st_run = 4'b0001,
		st_dummy = 4'b0010,
		st_vector = 4'b0100,
		st_halt = 4'b1000
	} fsm_t;

	typedef struct packed {
		logic powerdown_flag;
		logic timeout_flag;
		logic aux_carry_flag;
		logic carry;
		logic zero;
	} flags_t;

	typedef struct packed {
		op_t op;
		logic [`MEM_AW-1:0] mem_addr;
		logic [2:0] bit_idx;
		logic [7:0] imm;
		logic [`PC_W-1:0] target;
	} instr_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

	typedef struct packed {
		fsm_t fsm;
		logic ready;
		logic [`PC_W-1:0] pc;
		logic [7:0] acc;
		flags_t flags;
		logic master_irq_enable;
		logic [`SP_W-1:0] sp;
		logic [`STACK_DEPTH-1:0][`PC_W-1:0] stack;
		logic [`MEM_DEPTH-1:0][7:0] mem;
		logic [7:0] prescale;
		logic [7:0] watchdog_counter;
		logic last_pre_a;
		logic last_pre_b;
		logic [7:0] rdata;
	} exec_state_t;

endpackage

/* File: shared/exec_regs.svh */
// Constants for the instruction execute block
// Contract
// - AND combines accumulator with operand, zero only
// - OR combines accumulator with operand, zero only
// - Call pushes next address, two cycles
// - Jump loads target with one dummy cycle
// - Byte clear writes zero, no flags
// - Bit clear zeroes one bit only
// - Watchdog clear resets counter, timeout, powerdown
// - Pre-clears only act when alternated
// - Invert byte, zero flag, optional accumulator
// - Low nibble above nine or aux adds six
// - High nibble above nine or carry adds six
// - Decimal adjust writes memory, carry only
// - Decrement operand, zero flag only
// - Increment operand, zero flag only
// - Halt stops, clears watchdog, sets powerdown
// - Moves copy data, no flags touched
// - No-operation changes nothing, advances
// - Return pops stack into program counter
// - Return with value also loads accumulator
// - Interrupt return enables, pending serviced first
// - Rotate left, bit seven to bit zero
// - Rotate through carry, carry only changes
// - Pre-clear flags clear after consecutive pair
`ifndef EXEC_REGS_SVH
`define EXEC_REGS_SVH

`define PC_W 11
`define MEM_AW 5
`define MEM_DEPTH 32
`define SP_W 3
`define STACK_DEPTH 8
`define IRQ_VECTOR 11'h004

`define REG_ACC 8'h00
`define REG_STATUS 8'h01
`define REG_CTRL 8'h02
`define REG_PC_LO 8'h03
`define REG_PC_HI 8'h04
`define REG_WATCHDOG 8'h05
`define REG_SP 8'h06
`define REG_MEM_SEL 3'h1

`define STATUS_ZERO 0
`define STATUS_CARRY 1
`define STATUS_AUX 2
`define STATUS_TIMEOUT 3
`define STATUS_POWERDOWN 4
`define CTRL_IRQ_EN 0
`define CTRL_HALTED 1
`define CTRL_WAKE 2

`define NIBBLE_LIMIT 4'h9
`define ADJ_LOW 8'h06
`define ADJ_HIGH 8'h60
`define PRESCALE_MAX 8'hff
`define WATCHDOG_MAX 8'hff

`endif

/* File: verif/exec_monitor.sv */
// Port checks for the instruction execute block
`timescale 1ns/10ps
`default_nettype none
`include "exec_regs.svh"

module exec_monitor import exec_pkg::*; (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Instruction port
	input wire logic instr_valid,
	input wire instr_t instr,
	input wire logic instr_ready,
	// Interrupt, wake and register port
	input wire logic irq_pending,
	input wire logic wake,
	input wire bus_req_t bus,
	input wire logic [7:0] bus_rdata,
	// Core state
	input wire logic [`PC_W-1:0] pc,
	input wire logic [7:0] acc,
	input wire flags_t flags,
	input wire logic master_irq_enable,
	input wire logic clock_stop,
	input wire logic [7:0] watchdog_counter
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	logic take;
	op_t cur;
	assign take = instr_valid && instr_ready;
	assign cur = instr.op;
	call_load_a: assert property (take && cur == op_call |=>
		pc == $past(instr.target) && !instr_ready && flags == $past(flags))
		else $error("call target not loaded");
	// An interrupt in the dummy cycle may stretch ready low
	jump_load_a: assert property (take && cur == op_jump |=>
		pc == $past(instr.target) && !instr_ready ##1
		(instr_ready || irq_pending))
		else $error("jump timing wrong");
	and_imm_a: assert property (take && cur == op_and_acc_imm |=>
		acc == ($past(acc) & $past(instr.imm)) && flags.zero == (acc == 8'h00))
		else $error("and result wrong");
	or_imm_a: assert property (take && cur == op_or_acc_imm |=>
		acc == ($past(acc) | $past(instr.imm)) && flags.zero == (acc == 8'h00))
		else $error("or result wrong");
	nop_hold_a: assert property (take && cur == op_nop |=>
		acc == $past(acc) && flags == $past(flags) && pc == $past(pc) + 11'h001)
		else $error("nop changed state");
	wdt_clear_a: assert property (take && cur == op_watchdog_clear |=>
		flags[4:3] == 2'b00 && watchdog_counter == 8'h00)
		else $error("watchdog clear missed");
	halt_entry_a: assert property (take && cur == op_halt |=>
		clock_stop && flags[4:3] == 2'b10 && watchdog_counter == 8'h00
		&& !instr_ready)
		else $error("halt entry wrong");
	ret_imm_a: assert property (take && cur == op_return_imm |=>
		acc == $past(instr.imm) && flags == $past(flags))
		else $error("return value wrong");
	interrupt_return_op_irq_a: assert property (take && cur == op_interrupt_return
		|=> master_irq_enable && !instr_ready)
		else $error("interrupt enable not set");
	daa_acc_a: assert property (take && cur == op_decimal_adjust |=>
		acc == $past(acc) && flags.zero == $past(flags.zero))
		else $error("decimal adjust touched acc");
	cover property (take && cur == op_interrupt_return && irq_pending);
	cover property (take && cur == op_decimal_adjust);
	cover property (clock_stop && wake);
endmodule // exec_monitor

bind mcu_instruction_execute exec_monitor mon_u (.core_clk(core_clk),
	.rst(rst), .instr_valid(instr_valid), .instr(instr),
	.instr_ready(instr_ready), .irq_pending(irq_pending), .wake(wake),
	.bus(bus), .bus_rdata(bus_rdata), .pc(pc), .acc(acc), .flags(flags),
	.master_irq_enable(master_irq_enable), .clock_stop(clock_stop),
	.watchdog_counter(watchdog_counter));

`default_nettype wire

/* File: verif/instr_source.sv */
// Instruction source in place of the program sequencer
`timescale 1ns/10ps
`default_nettype none

module instr_source import exec_pkg::*; (
	// Clock and handshake
	input wire logic core_clk,
	input wire logic instr_ready,
	// Offered instruction
	output var logic instr_valid,
	output var instr_t instr
);
	initial begin
		instr_valid = 1'b0;
		instr = '0;
	end
	// Offer held until an edge sees ready; stale word inverted after
	task automatic send(instr_t i);
		@(posedge core_clk);
		instr_valid <= 1'b1;
		instr <= i;
		do @(negedge core_clk); while (instr_ready !== 1'b1);
		@(posedge core_clk);
		instr_valid <= 1'b0;
		instr <= ~i;
		@(negedge core_clk);
	endtask
endmodule // instr_source

`default_nettype wire

/* File: verif/mcu_instruction_execute_tb.sv */
// Self-checking bench for the execute block
`timescale 1ns/10ps
`default_nettype none
`include "exec_regs.svh"

module mcu_instruction_execute_tb import exec_pkg::*; ;
	logic core_clk, rst, irq_pending, wake, instr_valid, instr_ready;
	logic master_irq_enable, clock_stop;
	instr_t instr;
	bus_req_t bus;
	logic [7:0] bus_rdata, acc, watchdog_counter, d;
	logic [`PC_W-1:0] pc;
	flags_t flags;
	int miscompares = 0;
	int comparisons = 0;
	int cyc = 0;
	mcu_instruction_execute dut_u (.core_clk(core_clk), .rst(rst),
		.instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready),
		.irq_pending(irq_pending), .wake(wake), .bus(bus),
		.bus_rdata(bus_rdata), .pc(pc), .acc(acc), .flags(flags),
		.master_irq_enable(master_irq_enable), .clock_stop(clock_stop),
		.watchdog_counter(watchdog_counter));
	instr_source src_u (.core_clk(core_clk), .instr_ready(instr_ready),
		.instr_valid(instr_valid), .instr(instr));
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	task automatic wrap_up();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Run takes about eight hundred cycles
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			miscompares++;
			wrap_up();
		end
	end
	task automatic chk(logic [18:0] s, logic [18:0] e);
		comparisons++;
		if (s !== e) begin
			miscompares++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic put(logic [7:0] a, logic [7:0] v);
		@(posedge core_clk);
		bus <= '{a, v, 1'b1, 1'b0};
		@(posedge core_clk);
		bus <= '0;
		@(negedge core_clk);
	endtask
	task automatic get(logic [7:0] a);
		@(posedge core_clk);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge core_clk);
		bus <= '0;
		@(negedge core_clk);
		d = bus_rdata;
	endtask
	task automatic op(op_t o, logic [4:0] a, logic [10:0] v);
		src_u.send('{o, a, v[2:0], v[7:0], v});
	endtask
	task automatic s_logic();
		put(8'h00, 8'hf0);
		put(8'h23, 8'h3c);
		op(op_and_acc_mem, 5'd3, 11'h0);
		chk(acc, 8'h30);
		op(op_or_acc_imm, 5'd0, 11'h05);
		op(op_or_to_memory, 5'd3, 11'h0);
		get(8'h23);
		chk({d, acc}, 16'h3d35);
		op(op_and_to_memory, 5'd3, 11'h0);
		get(8'h23);
		chk(d, 8'h35);
		op(op_and_acc_imm, 5'd0, 11'h0a);
		chk({acc, flags.zero}, 9'h001);
		op(op_or_acc_mem, 5'd3, 11'h0);
		chk({acc, flags.zero}, 9'h06a);
		op(op_move_imm_to_acc, 5'd0, 11'h0a5);
		op(op_move_acc_to_mem, 5'd7, 11'h0);
		op(op_move_imm_to_acc, 5'd0, 11'h000);
		op(op_move_mem_to_acc, 5'd7, 11'h0);
		get(8'h10);
		chk({acc, d}, 16'ha500);
	endtask
	task automatic s_unary();
		put(8'h24, 8'hff);
		op(op_increment_to_acc, 5'd4, 11'h0);
		chk({acc, flags.zero}, 9'h001);
		op(op_increment_memory, 5'd4, 11'h0);
		get(8'h24);
		chk(d, 8'h00);
		op(op_decrement_memory, 5'd4, 11'h0);
		get(8'h24);
		chk({d, flags.zero}, 9'h1fe);
		op(op_decrement_to_acc, 5'd4, 11'h0);
		chk(acc, 8'hfe);
		op(op_clear_bit, 5'd4, 11'h5);
		get(8'h24);
		chk(d, 8'hdf);
		op(op_invert_memory, 5'd4, 11'h0);
		op(op_invert_to_acc, 5'd4, 11'h0);
		get(8'h24);
		chk({d, acc}, 16'h20df);
		op(op_clear_mem, 5'd4, 11'h0);
		get(8'h24);
		chk(d, 8'h00);
	endtask
	task automatic s_rotate();
		logic [7:0] ta [5] = '{8'h15, 8'h1c, 8'h12, 8'ha5, 8'h33};
		logic [1:0] tf [5] = '{2'd0, 2'd0, 2'd2, 2'd0, 2'd1};
		logic [8:0] te [5] = '{9'h02a, 9'h044, 9'h030, 9'h00b, 9'h127};
		put(8'h01, 8'h00);
		put(8'h25, 8'h81);
		op(op_rotate_left_to_acc, 5'd5, 11'h0);
		chk(acc, 8'h03);
		op(op_rotate_left_carry, 5'd5, 11'h0);
		op(op_rotate_left, 5'd5, 11'h0);
		get(8'h25);
		chk({d, flags.carry}, 9'h009);
		for (int k = 0; k < 5; k++) begin
			put(8'h00, ta[k]);
			put(8'h01, {5'h00, tf[k], 1'b0});
			op(op_decimal_adjust, 5'd6, 11'h0);
			get(8'h26);
			chk({d, flags.carry}, te[k]);
			chk(acc, ta[k]);
		end
	endtask
	task automatic s_flow();
		op(op_jump, 5'd0, 11'h040);
		chk(pc, 11'h040);
		op(op_call, 5'd0, 11'h123);
		chk(pc, 11'h123);
		op(op_call, 5'd0, 11'h200);
		op(op_return_imm, 5'd0, 11'h05a);
		chk({pc, acc}, 19'h1245a);
		op(op_return, 5'd0, 11'h0);
		chk(pc, 11'h041);
		op(op_nop, 5'd0, 11'h0);
		chk(pc, 11'h042);
	endtask
	task automatic s_irq();
		put(8'h02, 8'h01);
		@(posedge core_clk);
		irq_pending <= 1'b1;
		repeat (2) @(negedge core_clk);
		chk({pc, master_irq_enable}, 12'h008);
		op(op_interrupt_return, 5'd0, 11'h0);
		chk({pc, master_irq_enable}, 12'h085);
		@(negedge core_clk);
		chk(pc, 11'h004);
		@(posedge core_clk);
		irq_pending <= 1'b0;
		op(op_interrupt_return, 5'd0, 11'h0);
		chk(pc, 11'h042);
	endtask
	task automatic s_wdt();
		repeat (600) @(posedge core_clk);
		put(8'h01, 8'h18);
		op(op_watchdog_preclear_b, 5'd0, 11'h0);
		op(op_watchdog_preclear_b, 5'd0, 11'h0);
		chk({flags[4:3], watchdog_counter == 8'h00}, 3'b110);
		op(op_watchdog_preclear_a, 5'd0, 11'h0);
		op(op_watchdog_preclear_b, 5'd0, 11'h0);
		chk({flags[4:3], watchdog_counter}, 10'h000);
		put(8'h01, 8'h18);
		op(op_watchdog_clear, 5'd0, 11'h0);
		chk(flags[4:3], 2'b00);
	endtask
	task automatic s_halt();
		op(op_halt, 5'd0, 11'h0);
		chk({clock_stop, flags[4:3], instr_ready}, 4'b1100);
		@(posedge core_clk);
		wake <= 1'b1;
		@(posedge core_clk);
		wake <= 1'b0;
		repeat (2) @(negedge core_clk);
		chk(clock_stop, 1'b0);
	endtask
	initial begin
		rst = 1'b1;
		irq_pending = 1'b0;
		wake = 1'b0;
		bus = '0;
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		s_logic();
		s_unary();
		s_rotate();
		s_flow();
		s_irq();
		s_wdt();
		s_halt();
		wrap_up();
	end
endmodule // mcu_instruction_execute_tb

`default_nettype wire
